// ---- logic/sep_pkg.sv ----
// constants, types and encodings for the serial eeprom command port
// assumes a 25 MHz core clock that oversamples the host's serial pins
// Contract
// - cycle starts after select rises, start bit first
// - leading zeros ignored, first one is start
// - two opcode bits follow start bit directly
// - eight address bits, low seven select word
// - other commands decode opcode plus top address bits
// - opcode 10 read, 01 write, 11 erase
// - opcode 00: 11 enable, 01 all, 00 disable, 10 eraseall
// - sixteen data bits for write kinds, msb first
// - read sends zero dummy then word msb first
// - read output changes on serial clock rise
// - select fall ends cycle, starts programming
// - writes disabled after power up
// - write enable holds until disable command
// - enable acts only on select falling edge
// - reads ignore write enable state
// - write programs only when enabled
// - busy while programming, new commands refused
// - status low means busy, high ready
// - input sampled on serial clock rise while selected
// - deselected: ignore inputs, output released
// - select rise restarts command decoder
// - ready display cleared by clocked start bit; code also clears it on select fall when not busy
package sep_pkg;

  // core clock rate and programming time
  localparam int CLK_FREQ_MHZ  = 25;
  localparam int PROG_TIME_US  = 15000;                       // program_cycle_time, longest
  localparam int PROG_CYCLES   = PROG_TIME_US * CLK_FREQ_MHZ;  // longest time, exact product, no rounding
  localparam int PROG_CNT_W    = 20;

  // field widths and last-bit counts
  localparam int WORD_W        = 16;
  localparam int ADDR_W        = 8;
  localparam int WORD_ADDR_W   = 7;
  localparam int DEPTH         = 128;
  localparam logic [4:0] LAST_OPC_BIT  = 5'h01;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h07;
  localparam logic [4:0] LAST_DATA_BIT = 5'h0f;
  localparam logic [4:0] CNT_STEP      = 5'h01;
  localparam logic [4:0] CNT_ZERO      = 5'h00;

  // opcode and extended-command encodings
  localparam logic [1:0] OPC_EXT   = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ  = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] EXT_WRITE_DISABLE = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL     = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL     = 2'h2;
  localparam logic [1:0] EXT_WEN           = 2'h3;

  // data values
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hffff;
  localparam logic              DUMMY_BIT   = 1'h0;

  // decoder states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC  = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_READ = 6'h10,
    ST_DONE = 6'h20
  } sep_state_e;

  // decoded operations
  typedef enum logic [2:0] {
    OP_NONE          = 3'h0,
    OP_READ          = 3'h1,
    OP_WRITE         = 3'h2,
    OP_ERASE         = 3'h3,
    OP_WEN           = 3'h4,
    OP_WRITE_DISABLE = 3'h5,
    OP_WRITE_ALL     = 3'h6,
    OP_ERASE_ALL     = 3'h7
  } sep_op_e;

  // host pins as sampled
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } sep_pins_s;

  localparam int PINS_W = 3;

endpackage : sep_pkg

// ---- logic/sep_sync.sv ----
// two-flop synchroniser, one per bit
// assumes inputs come from outside the core clock domain
`timescale 1ns/1ps
module sep_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  genvar gi;
  for (gi = 0; gi < W; gi++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_q[gi]   <= 1'b0;
        sync_out[gi] <= 1'b0;
      end else begin
        meta_q[gi]   <= async_in[gi];
        sync_out[gi] <= meta_q[gi];
      end
    end
  end

endmodule : sep_sync

// ---- logic/sep_cmd_port.sv ----
// serial eeprom command port: decoder, 128 x 16 array, program timer
// assumes host pins are asynchronous and the serial clock is much slower than CORE_CLK
`timescale 1ns/1ps
module sep_cmd_port
  import sep_pkg::*;
#(
  parameter int P_PROG_CYCLES = PROG_CYCLES
) (
  // clock and reset
  input  wire logic CORE_CLK,
  input  wire logic SYS_RST,
  // host serial pins
  input  wire logic CS,
  input  wire logic SK,
  input  wire logic DI,
  // serial output pin
  output logic      SDO,
  output logic      SDO_OE
);

  localparam logic [PROG_CNT_W-1:0] PROG_LOAD = PROG_CNT_W'(P_PROG_CYCLES);
  localparam logic [PROG_CNT_W-1:0] PROG_ONE  = PROG_CNT_W'(1);

  sep_pins_s                 pins;
  logic                      cs_p_q, sk_p_q;
  logic                      cs_rise, cs_fall, sk_rise;
  sep_state_e                state_q, state_d;
  logic [4:0]                cnt_q, cnt_d;
  logic [1:0]                opc_q, opc_d;
  logic [ADDR_W-1:0]         addr_q, addr_d, new_addr;
  logic [WORD_W-1:0]         data_q, data_d, new_data;
  logic [WORD_W-1:0]         shout_q, shout_d;
  sep_op_e                   cmd_op_q, cmd_op_d, dec_op;
  logic                      wen_q, wen_d;
  logic                      busy_q, busy_d;
  logic                      ready_q, ready_d;
  logic [PROG_CNT_W-1:0]     prog_cnt_q, prog_cnt_d;
  sep_op_e                   prog_op_q, prog_op_d;
  logic [WORD_ADDR_W-1:0]    prog_addr_q, prog_addr_d;
  logic [WORD_W-1:0]         prog_data_q, prog_data_d;
  logic                      sdo_d, sdo_oe_d;
  logic                      commit, prog_all;
  logic [WORD_W-1:0]         prog_word;
  logic [WORD_W-1:0]         mem [DEPTH];

  // every host pin passes two flops before use
  sep_sync #(.W(PINS_W)) u_sync (
    .clk      (CORE_CLK),
    .rst      (SYS_RST),
    .async_in ({CS, SK, DI}),
    .sync_out (pins)
  );

  // edge detect on the synchronised levels
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      cs_p_q <= 1'b0;
      sk_p_q <= 1'b0;
    end else begin
      cs_p_q <= pins.cs;
      sk_p_q <= pins.sk;
    end
  end

  assign cs_rise = pins.cs & ~cs_p_q;
  assign cs_fall = ~pins.cs & cs_p_q;
  assign sk_rise = pins.sk & ~sk_p_q;

  // opcode plus top address bits to an operation
  function automatic sep_op_e decode(input logic [1:0] opc, input logic [1:0] hi);
    sep_op_e op;
    op = OP_NONE;
    case (opc)
      OPC_READ:  op = OP_READ;
      OPC_WRITE: op = OP_WRITE;
      OPC_ERASE: op = OP_ERASE;
      default: begin
        case (hi)
          EXT_WEN:           op = OP_WEN;
          EXT_WRITE_ALL:     op = OP_WRITE_ALL;
          EXT_WRITE_DISABLE: op = OP_WRITE_DISABLE;
          default:           op = OP_ERASE_ALL;
        endcase
      end
    endcase
    return op;
  endfunction : decode

  assign new_addr = {addr_q[ADDR_W-2:0], pins.di};
  assign new_data = {data_q[WORD_W-2:0], pins.di};   // msb arrives first
  assign dec_op   = decode(opc_q, new_addr[ADDR_W-1:ADDR_W-2]);

  // next state of decoder, write enable, program timer and output
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    opc_d       = opc_q;
    addr_d      = addr_q;
    data_d      = data_q;
    shout_d     = shout_q;
    cmd_op_d    = cmd_op_q;
    wen_d       = wen_q;
    busy_d      = busy_q;
    ready_d     = ready_q;
    prog_cnt_d  = prog_cnt_q;
    prog_op_d   = prog_op_q;
    prog_addr_d = prog_addr_q;
    prog_data_d = prog_data_q;
    sdo_d       = SDO;
    sdo_oe_d    = 1'b0;
    commit      = 1'b0;
    // self-timed programming runs regardless of the pins
    if (busy_q) begin
      if (prog_cnt_q == PROG_ONE) begin
        busy_d  = 1'b0;
        ready_d = 1'b1;
        commit  = 1'b1;
      end else begin
        prog_cnt_d = prog_cnt_q - PROG_ONE;
      end
    end
    if (cs_fall) begin
      state_d = ST_IDLE;
      if (!busy_q) begin
        ready_d = 1'b0;
      end
      // non-read commands act only when select falls after a complete frame
      if (state_q == ST_DONE) begin
        case (cmd_op_q)
          OP_WEN: wen_d = 1'b1;
          OP_WRITE_DISABLE: wen_d = 1'b0;
          OP_WRITE, OP_ERASE, OP_WRITE_ALL, OP_ERASE_ALL: begin
            if (wen_q) begin
              busy_d      = 1'b1;
              prog_cnt_d  = PROG_LOAD;
              prog_op_d   = cmd_op_q;
              prog_addr_d = addr_q[WORD_ADDR_W-1:0];
              prog_data_d = data_q;
            end
          end
          default: ;
        endcase
      end
    end else if (cs_rise) begin
      state_d = ST_IDLE;
      cnt_d   = CNT_ZERO;
    end else if (pins.cs && sk_rise) begin
      case (state_q)
        ST_IDLE: begin
          // zeros before the start bit fall through; busy refuses it
          if (pins.di && !busy_q) begin
            state_d = ST_OPC;
            cnt_d   = CNT_ZERO;
            ready_d = 1'b0;
          end
        end
        ST_OPC: begin
          opc_d = {opc_q[0], pins.di};
          if (cnt_q == LAST_OPC_BIT) begin
            state_d = ST_ADDR;
            cnt_d   = CNT_ZERO;
          end else begin
            cnt_d = cnt_q + CNT_STEP;
          end
        end
        ST_ADDR: begin
          addr_d = new_addr;
          if (cnt_q == LAST_ADDR_BIT) begin
            cmd_op_d = dec_op;
            cnt_d    = CNT_ZERO;
            if (dec_op == OP_READ) begin
              // top address bit dropped, enable not consulted
              state_d = ST_READ;
              shout_d = mem[new_addr[WORD_ADDR_W-1:0]];
              sdo_d   = DUMMY_BIT;
            end else if (dec_op == OP_WRITE || dec_op == OP_WRITE_ALL) begin
              state_d = ST_DATA;
            end else begin
              state_d = ST_DONE;
            end
          end else begin
            cnt_d = cnt_q + CNT_STEP;
          end
        end
        ST_DATA: begin
          data_d = new_data;
          if (cnt_q == LAST_DATA_BIT) begin
            state_d = ST_DONE;
          end else begin
            cnt_d = cnt_q + CNT_STEP;
          end
        end
        ST_READ: begin
          sdo_d   = shout_q[WORD_W-1];
          shout_d = {shout_q[WORD_W-2:0], 1'b0};
        end
        ST_DONE: ;                            // extra clocks are ignored
        default: state_d = ST_IDLE;
      endcase
    end
    // output enable: read data first, then status, else released
    if (!pins.cs) begin
      sdo_oe_d = 1'b0;
    end else if (state_d == ST_READ) begin
      sdo_oe_d = 1'b1;
    end else if (busy_q || ready_q) begin
      sdo_oe_d = 1'b1;
      sdo_d    = ~busy_q;
    end else begin
      sdo_oe_d = 1'b0;
    end
  end

  // register all command-port state
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_q     <= ST_IDLE;
      cnt_q       <= CNT_ZERO;
      opc_q       <= OPC_EXT;
      addr_q      <= '0;
      data_q      <= '0;
      shout_q     <= '0;
      cmd_op_q    <= OP_NONE;
      wen_q       <= 1'b0;
      busy_q      <= 1'b0;
      ready_q     <= 1'b0;
      prog_cnt_q  <= '0;
      prog_op_q   <= OP_NONE;
      prog_addr_q <= '0;
      prog_data_q <= '0;
      SDO         <= 1'b0;
      SDO_OE      <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      opc_q       <= opc_d;
      addr_q      <= addr_d;
      data_q      <= data_d;
      shout_q     <= shout_d;
      cmd_op_q    <= cmd_op_d;
      wen_q       <= wen_d;
      busy_q      <= busy_d;
      ready_q     <= ready_d;
      prog_cnt_q  <= prog_cnt_d;
      prog_op_q   <= prog_op_d;
      prog_addr_q <= prog_addr_d;
      prog_data_q <= prog_data_d;
      SDO         <= sdo_d;
      SDO_OE      <= sdo_oe_d;
    end
  end

  // array update at the end of the program time
  assign prog_all  = (prog_op_q == OP_WRITE_ALL) || (prog_op_q == OP_ERASE_ALL);
  assign prog_word = (prog_op_q == OP_WRITE || prog_op_q == OP_WRITE_ALL) ? prog_data_q : ERASED_WORD;

  // array words are nonvolatile: no reset
  genvar gi;
  for (gi = 0; gi < DEPTH; gi++) begin : g_word
    always_ff @(posedge CORE_CLK) begin
      if (commit && (prog_all || prog_addr_q == WORD_ADDR_W'(gi))) begin
        mem[gi] <= prog_word;
      end
    end
  end

  // checks
  a_oe_when_deselected: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !pins.cs |=> !SDO_OE) else $error("output driven while deselected");

  a_status_shows_busy: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    pins.cs && busy_q && state_d != ST_READ |=> SDO_OE && !SDO) else $error("busy status not low");

  a_wen_after_reset: assert property (@(posedge CORE_CLK)
    SYS_RST |=> !wen_q) else $error("write enable set after reset");

  a_wen_set_on_fall: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    $rose(wen_q) |-> $past(cs_fall) && $past(cmd_op_q) == OP_WEN) else $error("enable set outside select fall");

  a_wen_holds_set: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    wen_q && !(cs_fall && state_q == ST_DONE && cmd_op_q == OP_WRITE_DISABLE) |=> wen_q) else $error("enable lost");

  a_locked_no_busy: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    cs_fall && state_q == ST_DONE && !wen_q && !busy_q |=> !busy_q) else $error("program while disabled");

  a_prog_starts: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    cs_fall && state_q == ST_DONE && wen_q && cmd_op_q inside {OP_WRITE, OP_ERASE, OP_WRITE_ALL, OP_ERASE_ALL}
    |=> busy_q ##0 prog_cnt_q == PROG_LOAD) else $error("program not started");

  a_busy_refuses: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    busy_q && state_q == ST_IDLE |=> state_q == ST_IDLE) else $error("command accepted while busy");

  a_dummy_bit_first: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    pins.cs && sk_rise && !cs_fall && !cs_rise && state_q == ST_ADDR && cnt_q == LAST_ADDR_BIT
    && dec_op == OP_READ |=> SDO_OE && SDO == DUMMY_BIT) else $error("dummy bit missing");

  a_sdo_on_sk_rise: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    state_q == ST_READ && $past(state_q) == ST_READ && $changed(SDO) |-> $past(sk_rise))
    else $error("read data changed off clock rise");

  a_ready_cleared: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    pins.cs && sk_rise && !cs_rise && ready_q && !busy_q && state_q == ST_IDLE && pins.di |=> !ready_q)
    else $error("ready not cleared by start bit");

endmodule : sep_cmd_port

// ---- verif/sep_host_model.sv ----
// host master model: drives select, serial clock and data in, samples the answer
// assumes core_clk is the device clock; one serial clock period is 8 core clocks (320 ns)
`timescale 1ns/1ps
module sep_host_model (
  // clock
  input  wire logic core_clk,
  // host pins
  output logic      cs,
  output logic      sk,
  output logic      di,
  // device answer
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic [31:0] cap;      // sdo sampled before each serial clock rise
  logic        oe_seen;  // sdo_oe at the last sample

  // pins idle low; outside frames the serial clock moves only in noise
  initial begin
    cs      = 1'b0;
    sk      = 1'b0;
    di      = 1'b0;
    cap     = '0;
    oe_seen = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // sample at the falling core edge so registered outputs have settled
  task automatic grab();
    @(negedge core_clk);
    cap     = {cap[30:0], sdo_oe ? sdo : ~sdo};  // released pin never keeps its last value
    oe_seen = sdo_oe;
    @(posedge core_clk);
  endtask : grab

  // one whole frame, bit n-1 first
  task automatic frame(input logic [31:0] bits, input int n);
    cs <= 1'b1;
    tick(8);
    for (int i = n - 1; i >= 0; i--) begin
      di <= bits[i];
      tick(3);
      grab();
      sk <= 1'b1;
      tick(4);
      sk <= 1'b0;
    end
    tick(4);
    cs <= 1'b0;
    di <= ~di;                      // released line never keeps its last value
    tick(8);
  endtask : frame

  // status poll without serial clock
  task automatic poll();
    cs <= 1'b1;
    tick(8);
    grab();
    cs <= 1'b0;
    tick(8);
  endtask : poll

  // clock and data wiggle while deselected
  task automatic noise(input int n);
    repeat (n) begin
      sk <= ~sk;
      di <= ~di;
      tick(4);
    end
    sk <= 1'b0;
    tick(4);
  endtask : noise
endmodule : sep_host_model

// ---- verif/tb_top.sv ----
// self-checking bench for the serial eeprom command port
// assumes the host model above; programming time shortened to PROG core clocks
`timescale 1ns/1ps
module tb_top;
  import sep_pkg::*;
  localparam int PROG = 400;  // longer than one frame, so a frame fits inside a busy period

  logic core_clk;
  logic sys_rst;
  logic cs;
  logic sk;
  logic di;
  logic sdo;
  logic sdo_oe;
  int   failures;
  int   check_count;
  logic [15:0] rd;

  sep_cmd_port #(.P_PROG_CYCLES(PROG)) dut_u (
    .CORE_CLK(core_clk), .SYS_RST(sys_rst), .CS(cs), .SK(sk), .DI(di), .SDO(sdo), .SDO_OE(sdo_oe)
  );
  sep_host_model host_u (
    .core_clk(core_clk), .cs(cs), .sk(sk), .di(di), .sdo(sdo), .sdo_oe(sdo_oe)
  );

  // 25 MHz core clock
  initial core_clk = 1'b0;
  always #20 core_clk = ~core_clk;

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // command without data, or with a 16-bit data field
  task automatic send(input logic [1:0] opc, input logic [7:0] addr, input logic [15:0] data, input bit wd);
    if (wd) begin
      host_u.frame({5'h00, 1'b1, opc, addr, data}, 27);
    end else begin
      host_u.frame({21'h000000, 1'b1, opc, addr}, 11);
    end
  endtask : send

  // read: dummy bit then word, sampled before rises 12..28
  task automatic read_word(input logic [7:0] addr, output logic [15:0] data);
    host_u.frame({4'h0, 1'b1, OPC_READ, addr, 17'h00000}, 28);
    check("read dummy", 16'h0000, {15'h0000, host_u.cap[16]});
    check("read drive", 16'h0001, {15'h0000, host_u.oe_seen});
    data = host_u.cap[15:0];
  endtask : read_word

  // poll status until ready, bounded
  task automatic wait_ready(input bit busy_first);
    int tries;
    tries = 0;
    host_u.poll();
    if (busy_first) begin
      check("busy status", 16'h0002, {14'h0000, host_u.oe_seen, host_u.cap[0]});
    end
    while (host_u.cap[0] !== 1'b1 && tries < 60) begin
      host_u.poll();
      tries++;
    end
    check("ready status", 16'h0003, {14'h0000, host_u.oe_seen, host_u.cap[0]});
  endtask : wait_ready

  // writes refused after power up, no busy shown
  task automatic t_power_up();
    host_u.grab();
    check("oe after reset", 16'h0000, {15'h0000, host_u.oe_seen});
    send(OPC_WRITE, 8'h01, 16'h1234, 1'b1);
    host_u.poll();
    check("no busy when disabled", 16'h0000, {15'h0000, host_u.oe_seen});
  endtask : t_power_up

  // enable behind leading zeros, write with top address bit set, read back
  task automatic t_enable_write();
    host_u.frame({18'h00000, 3'h0, 1'b1, OPC_EXT, EXT_WEN, 6'h2a}, 14);
    send(OPC_WRITE, 8'h81, 16'ha5c3, 1'b1);
    wait_ready(1'b1);
    read_word(8'h01, rd);
    check("read word 1", 16'ha5c3, rd);
  endtask : t_enable_write

  // second write while busy is refused
  task automatic t_busy_refuse();
    send(OPC_WRITE, 8'h02, 16'h1111, 1'b1);
    send(OPC_WRITE, 8'h02, 16'h2222, 1'b1);
    wait_ready(1'b0);
    read_word(8'h02, rd);
    check("word 2 kept", 16'h1111, rd);
  endtask : t_busy_refuse

  // disabled: write, erase and erase-all change nothing, reads still work
  task automatic t_disabled();
    send(OPC_EXT, {EXT_WRITE_DISABLE, 6'h15}, 16'h0000, 1'b0);
    send(OPC_WRITE, 8'h01, 16'h0f0f, 1'b1);
    host_u.poll();
    check("no busy write", 16'h0000, {15'h0000, host_u.oe_seen});
    send(OPC_ERASE, 8'h02, 16'h0000, 1'b0);
    send(OPC_EXT, {EXT_ERASE_ALL, 6'h00}, 16'h0000, 1'b0);
    read_word(8'h01, rd);
    check("word 1 protected", 16'ha5c3, rd);
    read_word(8'h02, rd);
    check("word 2 protected", 16'h1111, rd);
  endtask : t_disabled

  // erase, write-all and erase-all with writes enabled
  task automatic t_codes();
    send(OPC_EXT, {EXT_WEN, 6'h00}, 16'h0000, 1'b0);
    send(OPC_ERASE, 8'h01, 16'h0000, 1'b0);
    wait_ready(1'b1);
    read_word(8'h01, rd);
    check("erased word", ERASED_WORD, rd);
    read_word(8'h02, rd);
    check("neighbour kept", 16'h1111, rd);
    send(OPC_EXT, {EXT_WRITE_ALL, 6'h3f}, 16'h3c5a, 1'b1);
    wait_ready(1'b1);
    read_word(8'h7f, rd);
    check("write-all top", 16'h3c5a, rd);
    read_word(8'h00, rd);
    check("write-all bottom", 16'h3c5a, rd);
    send(OPC_EXT, {EXT_ERASE_ALL, 6'h01}, 16'h0000, 1'b0);
    wait_ready(1'b1);
    read_word(8'h40, rd);
    check("erase-all", ERASED_WORD, rd);
  endtask : t_codes

  // ready left standing while deselected, cleared by the next start bit; cut frame does nothing
  task automatic t_ready_clear();
    send(OPC_WRITE, 8'h06, 16'h5a5a, 1'b1);
    host_u.tick(PROG + 40);
    read_word(8'h06, rd);
    check("ready shown then cleared", 16'h0002, {14'h0000, host_u.cap[27:26]});
    check("word 6", 16'h5a5a, rd);
    host_u.frame({25'h0, 1'b1, OPC_EXT, EXT_WRITE_DISABLE, 2'h0}, 7);
    send(OPC_WRITE, 8'h07, 16'h7777, 1'b1);
    wait_ready(1'b1);
    read_word(8'h07, rd);
    check("after cut frame", 16'h7777, rd);
  endtask : t_ready_clear

  // activity while deselected is ignored, output stays released
  task automatic t_deselect();
    host_u.noise(40);
    host_u.grab();
    check("oe deselected", 16'h0000, {15'h0000, host_u.oe_seen});
    read_word(8'h05, rd);
    check("array untouched", ERASED_WORD, rd);
  endtask : t_deselect

  // reset, then the scenarios in order
  initial begin
    sys_rst     = 1'b1;
    failures    = 0;
    check_count = 0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_power_up();
    t_enable_write();
    t_busy_refuse();
    t_disabled();
    t_codes();
    t_ready_clear();
    t_deselect();
    give_verdict();
  end

  // watchdog well beyond the expected run of about 8500 cycles
  initial begin
    #1600000;
    failures++;
    give_verdict();
  end
endmodule : tb_top
